/* File: qdl_defs.vh */
// Constants for the quad converter serial load control block
// ********************************************************
// ********************************************************
`ifndef QDL_DEFS_VH
`define QDL_DEFS_VH

// ********************************************************
// Serial frame
// ********************************************************
`define QDL_FRAME_BITS 32
`define QDL_CH_HI 21
`define QDL_CH_LO 20
`define QDL_DATA_HI 19
`define QDL_DATA_LO 4

// ********************************************************
// Codes
// ********************************************************
`define QDL_CODE_ZERO 16'h0000
`define QDL_CODE_MID 16'h8000
`define QDL_CODE_FULL 16'hFFFF
`define QDL_CLR_ZERO 2'h0
`define QDL_CLR_MID 2'h1
`define QDL_CLR_FULL 2'h2
`define QDL_POR_WAIT 2'h3

// ********************************************************
// Register map (byte addresses)
// ********************************************************
`define QDL_REG_CTRL 8'h00
`define QDL_REG_STATUS 8'h04
`define QDL_REG_WORD 8'h08
`define QDL_REG_CONV0 8'h10
`define QDL_REG_INPUT0 8'h20
`define QDL_CTRL_CLR_LO 0
`define QDL_CTRL_CLR_HI 1
`define QDL_CTRL_REF 2
`define QDL_CTRL_RESET 3'h0
`define QDL_RESP_OKAY 2'h0
`define QDL_RESP_SLVERR 2'h2

`endif

/* File: qdl_sync.v */
// Two-stage synchroniser for pin inputs
`default_nettype none

module qdl_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

/* File: qdl_shift.v */
// Serial frame receiver with shift register and serial output
`default_nettype none
`include "qdl_defs.vh"

module qdl_shift #(
  parameter BITS = `QDL_FRAME_BITS
) (
  input wire clock,
  input wire rst,
  input wire sclk_s,
  input wire frame_sync_n_s,
  input wire din_s,
  output reg word_valid,
  output reg [BITS-1:0] word,
  output reg frame_abort,
  output reg serial_out_pin
);

  reg sclk_prev;
  reg [BITS-1:0] shift;
  reg [5:0] count;
  wire sclk_fall;
  wire sclk_rise;

  assign sclk_fall = sclk_prev & ~sclk_s;
  assign sclk_rise = ~sclk_prev & sclk_s;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      // Idle level of the serial clock, no false rise after reset
      sclk_prev <= 1'b1;
      shift <= {BITS{1'b0}};
      count <= 6'h00;
      word_valid <= 1'b0;
      word <= {BITS{1'b0}};
      frame_abort <= 1'b0;
      serial_out_pin <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
      word_valid <= 1'b0;
      frame_abort <= 1'b0;
      if (frame_sync_n_s) begin
        // Partial frame dropped, nothing reaches the registers
        frame_abort <= (count != 6'h00) && (count < BITS[5:0]);
        count <= 6'h00;
      end else if (sclk_fall && count < BITS[5:0]) begin
        shift <= {shift[BITS-2:0], din_s};
        count <= count + 6'h01;
        if (count == BITS[5:0] - 6'h01) begin
          word_valid <= 1'b1;
          word <= {shift[BITS-2:0], din_s};
        end
      end
      // Oldest bit leaves on the rising edge for daisy-chaining
      if (sclk_rise) begin
        serial_out_pin <= shift[BITS-1];
      end
    end
  end

endmodule
`default_nettype wire

/* File: qdl_top.v */
// Quad converter serial load control with AXI4-Lite register access
`default_nettype none
`include "qdl_defs.vh"

module qdl_top #(
  parameter CODE_W = 16,
  parameter CHANNELS = 4
) (
  input wire clock,
  input wire rst,
  input wire sclk_pin,
  input wire frame_sync_n,
  input wire din_pin,
  input wire load_strobe_n,
  input wire async_clear_n,
  input wire por_level_pin,
  output wire serial_out_pin,
  output wire [CODE_W-1:0] dac_code0,
  output wire [CODE_W-1:0] dac_code1,
  output wire [CODE_W-1:0] dac_code2,
  output wire [CODE_W-1:0] dac_code3,
  output wire ref_internal_on,
  output wire ref_is_output,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ********************************************************
  // Helpers
  // ********************************************************
  function [CODE_W-1:0] clear_value;
    input [1:0] sel;
    begin
      case (sel)
        `QDL_CLR_MID: clear_value = `QDL_CODE_MID;
        `QDL_CLR_FULL: clear_value = `QDL_CODE_FULL;
        default: clear_value = `QDL_CODE_ZERO;
      endcase
    end
  endfunction

  // Unmapped offsets fall outside every window
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `QDL_REG_CTRL) || (addr == `QDL_REG_STATUS) ||
        (addr == `QDL_REG_WORD) ||
        (addr >= `QDL_REG_CONV0 && addr < `QDL_REG_INPUT0 + 8'h10 &&
        addr[1:0] == 2'h0);
    end
  endfunction

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  wire sclk_s;
  wire frame_n_s;
  wire din_s;
  wire load_n_s;
  wire clear_n_s;
  wire por_s;

  // Strobes and serial clock rest high so reset release makes no false edge
  qdl_sync #(
    .WIDTH(6),
    .RESET_VAL(6'h3E)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({sclk_pin, frame_sync_n, din_pin, load_strobe_n, async_clear_n,
      por_level_pin}),
    .sync_out({sclk_s, frame_n_s, din_s, load_n_s, clear_n_s, por_s})
  );

  // ********************************************************
  // Serial receiver
  // ********************************************************
  wire word_valid;
  wire [31:0] word;
  wire frame_abort;

  qdl_shift #(
    .BITS(`QDL_FRAME_BITS)
  ) u_shift (
    .clock(clock),
    .rst(rst),
    .sclk_s(sclk_s),
    .frame_sync_n_s(frame_n_s),
    .din_s(din_s),
    .word_valid(word_valid),
    .word(word),
    .frame_abort(frame_abort),
    .serial_out_pin(serial_out_pin)
  );

  // ********************************************************
  // Input and converter registers
  // ********************************************************
  reg [CODE_W-1:0] in_reg [0:CHANNELS-1];
  reg [CODE_W-1:0] conv_reg [0:CHANNELS-1];
  reg [CHANNELS-1:0] pending;
  reg [CHANNELS-1:0] next_pending;
  reg [1:0] por_cnt;
  reg por_done;
  reg clear_prev;
  reg [31:0] last_word;
  reg [7:0] abort_count;
  reg [2:0] ctrl;
  wire clear_fall;
  wire load_open;
  wire [1:0] word_ch;
  integer i;

  // Edge found on the synchronised copy only
  assign clear_fall = clear_prev & ~clear_n_s;
  assign load_open = ~load_n_s & clear_n_s;
  assign word_ch = word[`QDL_CH_HI:`QDL_CH_LO];

  always @* begin
    next_pending = pending;
    if (load_open) begin
      next_pending = {CHANNELS{1'b0}};
    end
    // New data beats a copy in the same cycle
    if (word_valid) begin
      next_pending[word_ch] = 1'b1;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        in_reg[i] <= `QDL_CODE_ZERO;
        conv_reg[i] <= `QDL_CODE_ZERO;
      end
      pending <= {CHANNELS{1'b0}};
      por_cnt <= 2'h0;
      por_done <= 1'b0;
      clear_prev <= 1'b1;
      last_word <= 32'h0000_0000;
      abort_count <= 8'h00;
    end else begin
      clear_prev <= clear_n_s;
      if (frame_abort && abort_count != 8'hFF) begin
        abort_count <= abort_count + 8'h01;
      end
      if (!por_done) begin
        // Level pin is caught once it has crossed both stages
        por_cnt <= por_cnt + 2'h1;
        if (por_cnt == `QDL_POR_WAIT) begin
          por_done <= 1'b1;
          for (i = 0; i < CHANNELS; i = i + 1) begin
            in_reg[i] <= por_s ? `QDL_CODE_MID : `QDL_CODE_ZERO;
            conv_reg[i] <= por_s ? `QDL_CODE_MID : `QDL_CODE_ZERO;
          end
        end
      end else if (clear_fall) begin
        for (i = 0; i < CHANNELS; i = i + 1) begin
          in_reg[i] <= clear_value(ctrl[`QDL_CTRL_CLR_HI:`QDL_CTRL_CLR_LO]);
          conv_reg[i] <= clear_value(ctrl[`QDL_CTRL_CLR_HI:`QDL_CTRL_CLR_LO]);
        end
        pending <= {CHANNELS{1'b0}};
      end else begin
        for (i = 0; i < CHANNELS; i = i + 1) begin
          if (load_open && pending[i]) begin
            conv_reg[i] <= in_reg[i];
          end
        end
        if (word_valid) begin
          in_reg[word_ch] <= word[`QDL_DATA_HI:`QDL_DATA_LO];
          last_word <= word;
        end
        pending <= next_pending;
      end
    end
  end

  assign dac_code0 = conv_reg[0];
  assign dac_code1 = conv_reg[1];
  assign dac_code2 = conv_reg[2];
  assign dac_code3 = conv_reg[3];
  assign ref_internal_on = ctrl[`QDL_CTRL_REF];
  assign ref_is_output = ctrl[`QDL_CTRL_REF];

  // ********************************************************
  // AXI4-Lite write channel
  // ********************************************************
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg w_strb0_q;
  wire aw_hs;
  wire w_hs;
  wire do_write;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire wr_strb0;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign do_write = (aw_held | aw_hs) & (w_held | w_hs);
  assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held ? w_data_q : s_axi_wdata;
  assign wr_strb0 = w_held ? w_strb0_q : s_axi_wstrb[0];

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `QDL_RESP_OKAY;
      ctrl <= `QDL_CTRL_RESET;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_addr) ? `QDL_RESP_OKAY : `QDL_RESP_SLVERR;
        // Only control is writable; other mapped words ignore data
        if (wr_addr == `QDL_REG_CTRL && wr_strb0) begin
          ctrl <= wr_data[2:0];
        end
      end else begin
        if (aw_hs) begin
          aw_held <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_hs) begin
          w_held <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb0_q <= s_axi_wstrb[0];
        end
      end
    end
  end

  // ********************************************************
  // AXI4-Lite read channel
  // ********************************************************
  reg [31:0] rd_word;
  wire [1:0] rd_idx;

  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx = s_axi_araddr[3:2];

  always @* begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == `QDL_REG_CTRL) begin
      rd_word = {29'h0000_0000, ctrl};
    end else if (s_axi_araddr == `QDL_REG_STATUS) begin
      rd_word = {16'h0000, abort_count, 1'b0, clear_n_s, load_n_s,
        por_done, pending};
    end else if (s_axi_araddr == `QDL_REG_WORD) begin
      rd_word = last_word;
    end else if (s_axi_araddr[7:4] == 4'h1) begin
      rd_word = {16'h0000, conv_reg[rd_idx]};
    end else if (s_axi_araddr[7:4] == 4'h2) begin
      rd_word = {16'h0000, in_reg[rd_idx]};
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `QDL_RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= mapped(s_axi_araddr) ? rd_word : 32'h0000_0000;
        s_axi_rresp <= mapped(s_axi_araddr) ? `QDL_RESP_OKAY : `QDL_RESP_SLVERR;
      end
    end
  end

endmodule
`default_nettype wire

/* File: qdl_sva.sv */
// Checker for the serial load control block
`default_nettype none
module qdl_sva #(
  parameter CODE_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk_pin,
  input wire logic load_strobe_n,
  input wire logic async_clear_n,
  input wire logic por_level_pin,
  input wire logic serial_out_pin,
  input wire logic [CODE_W-1:0] dac_code0,
  input wire logic [CODE_W-1:0] dac_code1,
  input wire logic [CODE_W-1:0] dac_code2,
  input wire logic [CODE_W-1:0] dac_code3,
  input wire logic ref_internal_on,
  input wire logic ref_is_output,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  // ****
  // Helpers
  // ****
  logic [3:0] cnt;
  logic [2:0] ctrl;
  logic wrote;
  logic ready;
  logic ar_bad;
  logic wr_go;
  logic [CODE_W-1:0] clr_val;
  assign ready = cnt == 4'hf;
  assign ar_bad = s_axi_araddr[1:0] != 2'h0 || s_axi_araddr == 8'h0c || s_axi_araddr > 8'h2c;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign clr_val = ctrl[1:0] == 2'h1 ? {1'b1, {(CODE_W-1){1'b0}}} :
                   ctrl[1:0] == 2'h2 ? {CODE_W{1'b1}} : {CODE_W{1'b0}};
  // The testbench presents address and data together, so one edge tracks CTRL
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      ctrl <= 3'h0;
      wrote <= 1'b0;
    end else begin
      if (!ready) cnt <= cnt + 4'h1;
      if (wr_go && s_axi_awaddr == 8'h00 && s_axi_wstrb[0]) begin
        ctrl <= s_axi_wdata[2:0];
        wrote <= 1'b1;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_quiet;
    (ready && load_strobe_n && async_clear_n)[*6];
  endsequence
  sequence s_clr_low;
    (ready && !async_clear_n)[*8];
  endsequence
  property p_hold;
    s_quiet |-> $stable(dac_code0) && $stable(dac_code1) && $stable(dac_code2)
      && $stable(dac_code3);
  endproperty
  a_hold: assert property (p_hold)
    else $error("converter moved with strobe high");
  property p_clr_block;
    s_clr_low |-> $stable(dac_code0) && $stable(dac_code1) && $stable(dac_code2)
      && $stable(dac_code3);
  endproperty
  a_clr_block: assert property (p_clr_block)
    else $error("converter moved while clear low");
  property p_clear;
    ready && $fell(async_clear_n) |-> ##[1:8] (dac_code0 == clr_val && dac_code3 == clr_val);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear code not loaded");
  property p_por;
    cnt == 4'h8 |-> dac_code0 == {por_level_pin, {(CODE_W-1){1'b0}}}
      && dac_code3 == {por_level_pin, {(CODE_W-1){1'b0}}};
  endproperty
  a_por: assert property (p_por)
    else $error("power-up code wrong");
  property p_ref;
    !wrote |-> !ref_internal_on && !ref_is_output;
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference on before enable");
  property p_sdo;
    ready && $changed(serial_out_pin) |-> sclk_pin && !$past(sclk_pin, 8);
  endproperty
  a_sdo: assert property (p_sdo)
    else $error("serial out moved off a rising clock");
  property p_bresp;
    wr_go |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response late");
  property p_rresp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && s_axi_rresp == ($past(ar_bad) ? 2'h2 : 2'h0);
  endproperty
  a_rresp: assert property (p_rresp)
    else $error("read response wrong");
endmodule
`default_nettype wire

/* File: qdl_host.sv */
// Host serial controller model driving write frames
`default_nettype none
module qdl_host (
  output logic sclk_pin,
  output logic frame_sync_n,
  output logic din_pin,
  input wire logic serial_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock idles high and stands still between frames
  initial begin
    sclk_pin = 1'b1;
    frame_sync_n = 1'b1;
    din_pin = 1'b0;
  end
  task automatic send(input logic [31:0] w, input int n, output logic [31:0] cap);
    // Off the system clock edge so no pin moves while it is sampled
    #1;
    frame_sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din_pin = w[31-i];
      #80;
      sclk_pin = 1'b0;
      cap = {cap[30:0], serial_out_pin};
      #80;
      sclk_pin = 1'b1;
    end
    #40;
    // Released line flips so a stale bit cannot pass
    din_pin = ~din_pin;
    frame_sync_n = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Testbench for the serial load control block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic load_strobe_n = 1'b1;
  logic async_clear_n = 1'b1;
  logic por_level_pin = 1'b1;
  logic sclk_pin, frame_sync_n, din_pin, serial_out_pin, ref_internal_on, ref_is_output;
  logic [15:0] dac_code0, dac_code1, dac_code2, dac_code3;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen;
  int n_fail = 0;
  int n_checks = 0;
  always #2 clock = ~clock;
  qdl_top u_qdl_top (.*);
  qdl_host u_qdl_host (.*);
  // ****
  // Helpers
  // ****
  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic lost();
    n_fail++;
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb_;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready === 1'b1;
      tw = s_axi_wvalid && s_axi_wready === 1'b1;
      tb_ = s_axi_bvalid === 1'b1;
      bresp_seen = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb_) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    lost();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready === 1'b1;
      tr = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    lost();
  endtask
  task automatic strobe();
    @(posedge clock);
    load_strobe_n <= 1'b0;
    cyc(4);
    load_strobe_n <= 1'b1;
    cyc(8);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_frames();
    logic [31:0] d, c;
    logic [1:0] r;
    chk(dac_code2, 16'h8000);
    rd(8'h00, d, r);
    chk(d, 32'h0000_0000);
    rd(8'h40, d, r);
    chk(r, 2'h2);
    wr(8'h40, 32'h0000_0007);
    chk(bresp_seen, 2'h2);
    s_axi_wstrb <= 4'he;
    wr(8'h00, 32'h0000_0007);
    s_axi_wstrb <= 4'hf;
    chk(bresp_seen, 2'h0);
    rd(8'h00, d, r);
    chk(d, 32'h0000_0000);
    chk(ref_internal_on, 1'b0);
    u_qdl_host.send(32'h0011_2340, 32, c);
    rd(8'h24, d, r);
    chk(d, 32'h0000_1234);
    chk(dac_code1, 16'h8000);
    strobe();
    chk(dac_code1, 16'h1234);
    chk(dac_code0, 16'h8000);
    u_qdl_host.send(32'h00a5_5a5f, 32, c);
    chk(c, 32'h0011_2340);
    u_qdl_host.send(32'h0000_fff0, 20, c);
    rd(8'h20, d, r);
    chk(d, 32'h0000_8000);
    rd(8'h04, d, r);
    chk(d[15:8], 8'h01);
  endtask
  task automatic t_tied();
    logic [31:0] c;
    @(posedge clock);
    load_strobe_n <= 1'b0;
    u_qdl_host.send(32'h003b_eef0, 32, c);
    chk(dac_code3, 16'hbeef);
    chk(dac_code2, 16'h55a5);
    @(posedge clock);
    load_strobe_n <= 1'b1;
  endtask
  task automatic t_clear();
    logic [15:0] e[4] = '{16'h0000, 16'h8000, 16'hffff, 16'h0000};
    logic [31:0] d, c;
    logic [1:0] r;
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, k);
      @(posedge clock);
      async_clear_n <= 1'b0;
      cyc(10);
      rd(8'h24, d, r);
      chk(d, e[k]);
      u_qdl_host.send(32'h0001_1110, 32, c);
      strobe();
      chk(dac_code0, e[k]);
      async_clear_n <= 1'b1;
      cyc(6);
    end
    wr(8'h00, 32'h0000_0004);
    cyc(4);
    chk(ref_is_output, 1'b1);
    chk(ref_internal_on, 1'b1);
  endtask
  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(10);
    t_frames();
    t_tied();
    t_clear();
    give_verdict();
  end
endmodule
bind qdl_top qdl_sva #(.CODE_W(CODE_W)) u_qdl_sva (.*);
`default_nettype wire
